// ==== rtl/sac_consts.svh ====
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// ************************************************************
// register map
// ************************************************************
`define SAC_ADDR_RESULT 8'hD0
`define SAC_ADDR_CTRL 8'hD1
`define SAC_CTRL_RESET 8'h40
`define SAC_BIT_IRQ_EN 7
`define SAC_BIT_DONE 6
`define SAC_BIT_START 5
`define SAC_BIT_POWER 4

// ************************************************************
// timing
// ************************************************************
`define SAC_CLK_DIV 12
`define SAC_DIV_W 4
`define SAC_RES_BITS 8
`define SAC_STEP_W 3
`define SAC_SAMPLE_W 6
`define SAC_CONV_TIME_NS 70000
`define SAC_REF_OSC_KHZ 8000

`endif

// ==== rtl/sac_pkg.sv ====
package sac_pkg;

    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_SAMPLE,
        SAC_STEP,
        SAC_DONE
    } sac_state_e;

    typedef struct packed {
        logic       irq_en;
        logic       done;
        logic       power_on;
    } sac_ctrl_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sac_bus_s;

endpackage : sac_pkg

// ==== rtl/sac_step_clock.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sac_consts.svh"

// ************************************************************
// divide-by-twelve step tick generator
// ************************************************************
module sac_step_clock
    import sac_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_restart,
    output logic o_tick
);
    logic [`SAC_DIV_W-1:0] cnt_q;
    logic [`SAC_DIV_W-1:0] cnt_d;
    wire last_w = (cnt_q == `SAC_DIV_W'(`SAC_CLK_DIV - 1));

    // restart realigns the step phase to a fresh conversion
    assign cnt_d = (i_restart || last_w) ? '0 : cnt_q + `SAC_DIV_W'(1);
    assign o_tick = last_w && !i_restart;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // sac_step_clock

`default_nettype wire

// ==== rtl/sac_converter.sv ====
// Behaviour
// - eight bits resolved MSB first by approximation
// - step clock is oscillator divided by twelve
// - conversion lasts about seventy microseconds
// - channel chosen by port setup, no select
// - start write with power bit set begins conversion, clears done
// - done flag set at conversion end
// - single shot, no automatic restart
// - start during conversion restarts it at once
// - start bit always reads as zero
// - done with enable raises interrupt vector four
// - done is pending flag until restart
// - power bit enables, clear powers down
// - wait mode leaves converter running
// - completion interrupt wakes processor from wait
// - reset aborts conversion, control becomes 40h
// - result register is read-only at D0h
`timescale 1ns/10ps
`default_nettype none
`include "sac_consts.svh"

module sac_converter
    import sac_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_wait_mode,
    input wire logic i_cmp_above,
    output logic [7:0] o_rdata,
    output logic o_rd_hit,
    output logic [7:0] o_dac_code,
    output logic o_analog_power,
    output logic o_sample,
    output logic o_irq_vec4,
    output logic o_wake
);
    // ************************************************************
    // timing figures
    // ************************************************************
    // cycles of a whole conversion at the reference oscillator
    localparam int CONV_CYC_REF =
        (`SAC_CONV_TIME_NS * `SAC_REF_OSC_KHZ) / 1000000;
    // whole step ticks spent settling before the first bit is tested
    localparam int SAMPLE_TICKS =
        CONV_CYC_REF / `SAC_CLK_DIV - `SAC_RES_BITS;
    localparam logic [`SAC_SAMPLE_W-1:0] SAMPLE_LAST =
        `SAC_SAMPLE_W'(SAMPLE_TICKS - 1);
    localparam logic [7:0] CTRL_RST = `SAC_CTRL_RESET;
    localparam sac_ctrl_s CTRL_RST_S = '{
        irq_en: CTRL_RST[`SAC_BIT_IRQ_EN],
        done: CTRL_RST[`SAC_BIT_DONE],
        power_on: CTRL_RST[`SAC_BIT_POWER]
    };

    // ************************************************************
    // bus decode
    // ************************************************************
    sac_bus_s bus_w;
    assign bus_w = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    wire ctrl_sel_w = (bus_w.addr == `SAC_ADDR_CTRL);
    wire res_sel_w = (bus_w.addr == `SAC_ADDR_RESULT);
    wire ctrl_wr_w = bus_w.wr && ctrl_sel_w;
    wire start_w = ctrl_wr_w && bus_w.wdata[`SAC_BIT_START];

    // ************************************************************
    // state
    // ************************************************************
    sac_ctrl_s ctrl_q;
    sac_ctrl_s ctrl_d;
    sac_state_e state_q;
    sac_state_e state_d;
    logic [7:0] trial_q;
    logic [7:0] trial_d;
    logic [`SAC_STEP_W-1:0] bit_q;
    logic [`SAC_STEP_W-1:0] bit_d;
    logic [7:0] result_q;
    logic [7:0] result_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rd_hit_q;
    logic [`SAC_SAMPLE_W-1:0] samp_q;
    logic [`SAC_SAMPLE_W-1:0] samp_d;
    logic tick_w;

    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction

    function automatic logic [`SAC_STEP_W-1:0] lower_bit(
        input logic [`SAC_STEP_W-1:0] idx);
        lower_bit = idx - `SAC_STEP_W'(1);
    endfunction

    sac_step_clock u_step (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_restart(start_w),
        .o_tick(tick_w)
    );

    // ************************************************************
    // successive approximation sequencer
    // ************************************************************
    wire powered_w = ctrl_q.power_on;
    // wait mode is not an input to the sequencer at all
    wire unused_w = i_wait_mode;
    wire last_bit_w = (bit_q == '0);
    wire [7:0] cur_mask_w = bit_mask(bit_q);
    // keep the tested bit if the input is above the trial level
    wire [7:0] kept_w = i_cmp_above ? trial_q : (trial_q & ~cur_mask_w);
    wire [7:0] next_trial_w = last_bit_w ? kept_w :
        (kept_w | bit_mask(lower_bit(bit_q)));
    wire finish_w = (state_q == SAC_STEP) && tick_w && last_bit_w;
    wire sample_end_w = (samp_q == SAMPLE_LAST);
    // a start in the finishing cycle begins afresh, so it beats the set
    wire done_clr_w = start_w;
    wire done_set_w = finish_w && powered_w && !start_w;

    always_comb begin
        state_d = state_q;
        trial_d = trial_q;
        bit_d = bit_q;
        samp_d = samp_q;
        if (start_w && bus_w.wdata[`SAC_BIT_POWER]) begin
            // restart wins over anything in progress
            state_d = SAC_SAMPLE;
            trial_d = bit_mask(3'(`SAC_RES_BITS - 1));
            bit_d = `SAC_STEP_W'(`SAC_RES_BITS - 1);
            samp_d = '0;
        end else if (!powered_w) begin
            state_d = SAC_IDLE;
        end else begin
            unique case (state_q)
                SAC_IDLE: state_d = SAC_IDLE;
                SAC_SAMPLE: begin
                    if (tick_w && sample_end_w) begin
                        state_d = SAC_STEP;
                    end else if (tick_w) begin
                        samp_d = samp_q + `SAC_SAMPLE_W'(1);
                    end
                end
                SAC_STEP: begin
                    if (tick_w) begin
                        trial_d = next_trial_w;
                        bit_d = lower_bit(bit_q);
                        if (last_bit_w) begin
                            state_d = SAC_DONE;
                        end
                    end
                end
                SAC_DONE: state_d = SAC_IDLE;
            endcase
        end
    end

    // ************************************************************
    // control and result registers
    // ************************************************************
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr_w) begin
            ctrl_d.irq_en = bus_w.wdata[`SAC_BIT_IRQ_EN];
            ctrl_d.power_on = bus_w.wdata[`SAC_BIT_POWER];
        end
        if (done_clr_w) begin
            ctrl_d.done = 1'b0;
        end else if (done_set_w) begin
            ctrl_d.done = 1'b1;
        end
    end

    // result changes only together with the done flag
    assign result_d = done_set_w ?
        kept_w : result_q;

    wire [7:0] ctrl_view_w = {ctrl_q.irq_en, ctrl_q.done, 1'b0,
        ctrl_q.power_on, 4'h0};
    assign rdata_d = !bus_w.rd ? rdata_q :
        ctrl_sel_w ? ctrl_view_w :
        res_sel_w ? result_q : 8'h00;

    wire rd_hit_d = bus_w.rd && (ctrl_sel_w || res_sel_w);

    // ************************************************************
    // sequencer registers
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= SAC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            trial_q <= 8'h00;
        end else begin
            trial_q <= trial_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bit_q <= '0;
        end else begin
            bit_q <= bit_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            samp_q <= '0;
        end else begin
            samp_q <= samp_d;
        end
    end

    // ************************************************************
    // bus registers
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_q <= CTRL_RST_S;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            result_q <= 8'h00;
        end else begin
            result_q <= result_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_hit_q <= 1'b0;
        end else begin
            rd_hit_q <= rd_hit_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_rdata = rdata_q;
    assign o_rd_hit = rd_hit_q;
    assign o_dac_code = trial_q;
    assign o_analog_power = ctrl_q.power_on;
    assign o_sample = (state_q == SAC_SAMPLE);
    assign o_irq_vec4 = ctrl_q.done && ctrl_q.irq_en;
    assign o_wake = ctrl_q.done && ctrl_q.irq_en && i_wait_mode;
endmodule // sac_converter

`default_nettype wire

// ==== verification/sac_analog_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********
// one analog line seen through the comparator
// ********
module sac_analog_model (
    input wire logic [7:0] i_level,
    input wire logic [7:0] i_dac_code,
    output logic o_above
);
    assign o_above = i_level >= i_dac_code;
endmodule // sac_analog_model
`default_nettype wire

// ==== verification/sac_converter_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module sac_converter_properties (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_wait_mode,
    input wire logic [7:0] o_rdata,
    input wire logic o_rd_hit,
    input wire logic [7:0] o_dac_code,
    input wire logic o_analog_power,
    input wire logic o_sample,
    input wire logic o_irq_vec4,
    input wire logic o_wake
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    wire cw = i_wr && i_addr == 8'hD1;
    start_clears_a: assert property (
        cw && i_wdata[5] |=> !o_irq_vec4) else $error("done kept");
    restart_sample_a: assert property (
        cw && i_wdata[5] && i_wdata[4] |=> o_sample && o_dac_code == 8'h80)
        else $error("no fresh start");
    sample_len_a: assert property (
        $rose(o_sample) |-> o_sample[*8]) else $error("short sample");
    irq_mask_a: assert property (
        cw && !i_wdata[7] |=> !o_irq_vec4) else $error("irq unmasked");
    wake_gate_a: assert property (
        o_wake == (o_irq_vec4 && i_wait_mode)) else $error("bad wake");
    ctrl_read_a: assert property (
        i_rd && i_addr == 8'hD1 |=> o_rdata[5] == 1'b0
        && o_rdata[3:0] == 4'h0) else $error("bits not zero");
    power_bit_a: assert property (
        cw |=> o_analog_power == $past(i_wdata[4])) else $error("power");
    single_shot_a: assert property (
        o_irq_vec4 && !cw |=> !o_sample) else $error("auto restart");
    unmapped_read_a: assert property (
        i_rd && i_addr[7:1] != 7'h68 |=> !o_rd_hit && o_rdata == 8'h00)
        else $error("unmapped read");
endmodule // sac_converter_properties
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sac_consts.svh"
module tb_top;
    logic clk = 0, nrst = 0, wr = 0, rd = 0, wm = 0, hit, above, irq;
    logic [7:0] addr = 8'h00, wd = 8'h00, lvl = 8'h00, rdata, dac;
    logic [7:0] exp_q[$];
    int fail_count = 0, total_checks = 0, n, cyc = 0, seed = 41;
    // clock cycles in the whole step ticks of a conversion near seventy microseconds at 8 MHz
    localparam int CONV_CYC = ((`SAC_CONV_TIME_NS * `SAC_REF_OSC_KHZ /
        1000000) / `SAC_CLK_DIV) * `SAC_CLK_DIV;
    localparam int WAIT_LIM = CONV_CYC + 150;
    localparam int TIME_LIM = 10 * WAIT_LIM;
    sac_converter i_sac_converter (.i_clk(clk), .i_nrst(nrst),
        .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
        .i_wait_mode(wm), .i_cmp_above(above), .o_rdata(rdata),
        .o_rd_hit(hit), .o_dac_code(dac), .o_analog_power(),
        .o_sample(), .o_irq_vec4(irq), .o_wake());
    sac_analog_model i_sac_analog_model (.i_level(lvl),
        .i_dac_code(dac), .o_above(above));
    initial forever #25 clk = ~clk;
    task automatic cmp(input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic cmp_cyc(input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, d);
        wr = w;
        rd = !w;
        addr = a;
        wd = d;
        @(posedge clk);
        #1;
        wr = 0;
        rd = 0;
        // idle edge so back-to-back calls never retoggle a strobe
        @(posedge clk);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, e);
        exp_q.push_back(e);
        acc(0, a, 8'h00);
    endtask
    task automatic conv(input logic [7:0] c);
        acc(1, 8'hD1, c & 8'hDF);
        acc(1, 8'hD1, c);
        n = 0;
        while (!irq && n < WAIT_LIM) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) if (hit) cmp(exp_q.pop_front(), rdata);
    always @(posedge clk) begin
        cyc++;
        if (cyc == TIME_LIM) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        #1;
        nrst = 1;
        rd_chk(8'hD1, 8'h40);
        rd_chk(8'hD0, 8'h00);
        acc(0, 8'h42, 8'h00);
        $display("reset test done");
        wm = 1;
        for (int i = 0; i < 3; i++) begin
            lvl = 8'($random(seed));
            conv(8'hB0);
            cmp_cyc(16'(CONV_CYC - 1), 16'(n));
            rd_chk(8'hD0, lvl);
            rd_chk(8'hD1, 8'hD0);
        end
        $display("convert test done");
        acc(1, 8'hD1, 8'hB0);
        rd_chk(8'hD1, 8'h90);
        rd_chk(8'hD0, lvl);
        repeat (500) @(posedge clk);
        #1;
        lvl = 8'($random(seed));
        conv(8'hB0);
        cmp_cyc(16'(CONV_CYC - 1), 16'(n));
        rd_chk(8'hD0, lvl);
        acc(1, 8'hD0, ~lvl);
        rd_chk(8'hD0, lvl);
        $display("restart test done");
        conv(8'h30);
        cmp_cyc(16'(WAIT_LIM), 16'(n));
        rd_chk(8'hD1, 8'h50);
        acc(1, 8'hD1, 8'h80);
        rd_chk(8'hD1, 8'hC0);
        acc(1, 8'hD1, 8'h90);
        acc(1, 8'hD1, 8'hB0);
        repeat (30) @(posedge clk);
        #1;
        nrst = 0;
        @(posedge clk);
        #1;
        nrst = 1;
        rd_chk(8'hD1, 8'h40);
        rd_chk(8'hD0, 8'h00);
        repeat (3) @(posedge clk);
        $display("mask power reset test done");
        conclude();
    end
endmodule // tb_top
bind sac_converter sac_converter_properties i_sac_converter_properties (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_wait_mode(i_wait_mode),
    .o_rdata(o_rdata), .o_rd_hit(o_rd_hit), .o_dac_code(o_dac_code),
    .o_analog_power(o_analog_power), .o_sample(o_sample),
    .o_irq_vec4(o_irq_vec4), .o_wake(o_wake));
`default_nettype wire
